// *** hdl/rsc_pkg.sv ***
// Constants, register map and state type for the reset source controller.
package rsc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // Power-on release delay; a longest time, so the count rounds down.
  localparam int POR_DELAY_NS = 300000;
  localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
  // Supply monitor settling time; a least time, so the count rounds up.
  localparam int SETTLE_NS = 5000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 8;
  // Length of an internally forced (flash error) reset.
  localparam int FLASH_HOLD_CYC = 4;
  localparam int TIMER_W = 16;
  // Cycles the pin input is ignored after the block stops driving it.
  localparam logic [1:0] PIN_BLANK_CYC = 2'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word per register)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] MON_CTRL_ADDR = 4'h0;
  localparam logic [3:0] CAUSE_ADDR = 4'h4;
  localparam int MON_EN_BIT = 7;
  localparam int SUPPLY_STAT_BIT = 6;
  localparam int PIN_FLAG_BIT = 0;
  localparam int POR_FLAG_BIT = 1;
  localparam int FLASH_ERR_BIT = 6;

  // ----------------------------------------------------------------
  // Defaults applied to the core on reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
  localparam logic [15:0] START_ADDR = 16'h0000;
  localparam logic [3:0] WDT_PRESCALE = 4'hc;

  // Reset sequencing states.
  typedef enum logic [2:0] {
    ST_POR_HOLD,
    ST_POR_DELAY,
    ST_SUPPLY_HOLD,
    ST_PIN_HOLD,
    ST_FLASH_HOLD,
    ST_RUN
  } rsc_state_t;

endpackage

// *** hdl/rsc_timer_if.sv ***
// Interface between the sequencer and its delay timer.
`timescale 1ns/10ps
interface rsc_timer_if #(parameter int W = 16);
  logic start;        // Load the timer this cycle.
  logic [W-1:0] load; // Cycles to count.
  logic done;         // Timer has reached zero.
  modport ctrl (output start, output load, input done);
  modport timer (input start, input load, output done);
endinterface

// *** hdl/rsc_sync.sv ***
// Two-flop synchroniser for pin-level inputs.
`timescale 1ns/10ps
module rsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1; // First flop, read only by the second.
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Both flops take the quiet level in reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule // rsc_sync

// *** hdl/rsc_timer.sv ***
// Down-counting delay timer used by the reset sequencer.
`timescale 1ns/10ps
module rsc_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Control from the sequencer.
  rsc_timer_if.timer tif
);

  logic [W-1:0] count; // Remaining cycles.
  logic [W-1:0] next_count;

  // A start reloads even while counting, so the caller never waits.
  always_comb begin
    if (tif.start) begin
      next_count = tif.load;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign tif.done = (count == '0);

endmodule // rsc_timer

// *** hdl/rsc_reset_source_controller.sv ***
// Reset source controller: sequencing, cause flags and monitor control.
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module rsc_reset_source_controller
  import rsc_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = POR_DELAY_CYC
) (
  // Clock and power-on reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Avalon-MM register slave.
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Supply monitor side.
  input wire logic supply_above_threshold,
  output logic supply_monitor_on,
  // External active-low reset pin, open drain.
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Core side.
  input wire logic flash_write_attempt,
  output logic core_hold,
  output logic core_exit_pulse,
  output logic [7:0] port_latch_init,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic [15:0] start_address,
  output logic sysclk_internal_sel,
  output logic watchdog_run,
  output logic [3:0] watchdog_prescale
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic pin_sync;            // Synchronised reset pin level.
  logic supply_ok;           // Synchronised monitor output.
  rsc_state_t state;         // Sequencer state.
  rsc_state_t next_state;
  logic timer_start;         // Loads the delay timer.
  logic [TIMER_W-1:0] timer_load;
  logic [SETTLE_W-1:0] settle_cnt; // Monitor settling countdown.
  logic [SETTLE_W-1:0] next_settle_cnt;
  logic settled;             // Monitor output may be trusted.
  logic [1:0] pin_blank;     // Masks our own pin drive echo.
  logic [1:0] next_pin_blank;
  logic pin_reset_req;       // Genuine external pin reset.
  logic supply_reset_req;    // Monitor asks for reset.
  logic flash_reset_req;     // Illegal flash write.
  logic leaving;             // Last cycle of a reset state.
  logic monitor_enable;      // Monitor switched on.
  logic monitor_select;      // Monitor is a reset source.
  logic power_on_flag;
  logic pin_reset_flag;
  logic flash_error_flag;
  logic next_monitor_enable;
  logic next_monitor_select;
  logic next_power_on_flag;
  logic next_pin_reset_flag;
  logic next_flash_error_flag;
  logic ack;                 // Second cycle of a bus access.
  logic next_ack;
  logic [31:0] next_readdata;
  logic wr_commit;           // Write takes effect this edge.
  logic next_core_hold;
  logic next_pin_oe;
  logic next_exit_pulse;

  rsc_timer_if #(.W(TIMER_W)) tif ();

  // Address decode shared by read and write paths.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // The pin idles high, so it resets high and never fakes a reset.
  rsc_sync #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(reset_pin_in),
    .sync_out(pin_sync)
  );

  // Supply is assumed low until the monitor proves otherwise.
  rsc_sync #(.W(1), .RST_VAL(1'b0)) u_supply_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(supply_above_threshold),
    .sync_out(supply_ok)
  );

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  rsc_timer #(.W(TIMER_W)) u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .tif(tif.timer)
  );

  assign tif.start = timer_start;
  assign tif.load = timer_load;

  // ----------------------------------------------------------------
  // Monitor settling and pin echo blanking
  // ----------------------------------------------------------------
  // The monitor output is not trusted until it has settled after
  // being switched on; while it is off the count is held full.
  always_comb begin
    if (!monitor_enable) begin
      next_settle_cnt = SETTLE_W'(SETTLE_CYC);
    end else if (settle_cnt != '0) begin
      next_settle_cnt = settle_cnt - SETTLE_W'(1);
    end else begin
      next_settle_cnt = settle_cnt;
    end
    // Our own low drive returns through the synchroniser late, so
    // the pin is ignored for a few cycles after we let go of it.
    if (reset_pin_oe && !next_pin_oe) begin
      next_pin_blank = PIN_BLANK_CYC;
    end else if (pin_blank != 2'h0) begin
      next_pin_blank = pin_blank - 2'h1;
    end else begin
      next_pin_blank = pin_blank;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      settle_cnt <= SETTLE_W'(SETTLE_CYC);
      pin_blank <= 2'h0;
    end else begin
      settle_cnt <= next_settle_cnt;
      pin_blank <= next_pin_blank;
    end
  end

  assign settled = (settle_cnt == '0);

  // ----------------------------------------------------------------
  // Reset requests
  // ----------------------------------------------------------------
  // A pin held low by outside circuitry forces a reset.
  assign pin_reset_req = !pin_sync && !reset_pin_oe && (pin_blank == 2'h0);
  // An unsettled monitor counts as a low supply, so selecting it
  // too early resets the device straight away.
  assign supply_reset_req = monitor_enable && monitor_select && (!supply_ok || !settled);
  // Flash programming without the monitor is refused by a reset.
  assign flash_reset_req = flash_write_attempt && !monitor_enable;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Supply faults outrank the pin, which outranks flash errors.
  always_comb begin
    next_state = state;
    timer_start = 1'b0;
    timer_load = '0;
    unique case (state)
      ST_POR_HOLD: begin
        // Wait for the supply, then run the power-on delay.
        if (supply_ok) begin
          next_state = ST_POR_DELAY;
          timer_start = 1'b1;
          timer_load = TIMER_W'(POR_DELAY_CYCLES);
        end
      end
      ST_POR_DELAY: begin
        // A dip during the delay restarts the whole power-up.
        if (!supply_ok) begin
          next_state = ST_POR_HOLD;
        end else if (tif.done) begin
          next_state = ST_RUN;
        end
      end
      ST_SUPPLY_HOLD: begin
        // Held until the supply is back above threshold and the monitor has settled.
        if (supply_ok && settled) begin
          next_state = ST_RUN;
        end
      end
      ST_PIN_HOLD: begin
        // Released as soon as the pin rises again.
        if (pin_sync) begin
          next_state = ST_RUN;
        end
      end
      ST_FLASH_HOLD: begin
        if (tif.done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (supply_reset_req) begin
          next_state = ST_SUPPLY_HOLD;
        end else if (pin_reset_req) begin
          next_state = ST_PIN_HOLD;
        end else if (flash_reset_req) begin
          next_state = ST_FLASH_HOLD;
          timer_start = 1'b1;
          timer_load = TIMER_W'(FLASH_HOLD_CYC);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  assign leaving = (state != ST_RUN) && (next_state == ST_RUN);

  // ----------------------------------------------------------------
  // Control and cause flags
  // ----------------------------------------------------------------
  assign wr_commit = write && ack && byteenable[0];

  always_comb begin
    next_monitor_enable = monitor_enable;
    next_monitor_select = monitor_select;
    next_power_on_flag = power_on_flag;
    next_pin_reset_flag = pin_reset_flag;
    next_flash_error_flag = flash_error_flag;
    // Software writes; the enable survives every non-power-on reset.
    if (wr_commit && addr_hit(address, MON_CTRL_ADDR)) begin
      next_monitor_enable = writedata[MON_EN_BIT];
    end
    // Writing the power-on flag position selects the monitor.
    if (wr_commit && addr_hit(address, CAUSE_ADDR)) begin
      next_monitor_select = writedata[POR_FLAG_BIT];
    end
    // Flags are written by hardware only, on the way out of reset.
    if (leaving) begin
      unique case (state)
        ST_POR_DELAY: begin
          next_power_on_flag = 1'b1;
          next_pin_reset_flag = 1'b0;
          next_flash_error_flag = 1'b0;
        end
        ST_SUPPLY_HOLD: begin
          next_power_on_flag = 1'b1;
          next_pin_reset_flag = 1'b0;
          next_flash_error_flag = 1'b0;
        end
        ST_PIN_HOLD: begin
          next_power_on_flag = 1'b0;
          next_pin_reset_flag = 1'b1;
          next_flash_error_flag = 1'b0;
        end
        ST_FLASH_HOLD: begin
          next_power_on_flag = 1'b0;
          next_pin_reset_flag = 1'b0;
          next_flash_error_flag = 1'b1;
        end
        default: begin
          next_power_on_flag = power_on_flag;
        end
      endcase
    end
  end

  // Power-on leaves the monitor enabled and selected.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      monitor_enable <= 1'b1;
      monitor_select <= 1'b1;
      power_on_flag <= 1'b0;
      pin_reset_flag <= 1'b0;
      flash_error_flag <= 1'b0;
    end else begin
      monitor_enable <= next_monitor_enable;
      monitor_select <= next_monitor_select;
      power_on_flag <= next_power_on_flag;
      pin_reset_flag <= next_pin_reset_flag;
      flash_error_flag <= next_flash_error_flag;
    end
  end

  assign supply_monitor_on = monitor_enable;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Every access takes exactly one wait cycle; read data is loaded
  // in that cycle so it stands when waitrequest falls.
  always_comb begin
    next_ack = (read || write) && !ack;
    next_readdata = readdata;
    if (read && !ack) begin
      next_readdata = 32'h0000_0000;
      if (addr_hit(address, MON_CTRL_ADDR)) begin
        next_readdata[MON_EN_BIT] = monitor_enable;
        next_readdata[SUPPLY_STAT_BIT] = supply_ok;
      end else if (addr_hit(address, CAUSE_ADDR)) begin
        next_readdata[PIN_FLAG_BIT] = pin_reset_flag;
        next_readdata[POR_FLAG_BIT] = power_on_flag;
        next_readdata[FLASH_ERR_BIT] = flash_error_flag;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      readdata <= next_readdata;
    end
  end

  assign waitrequest = (read || write) && !ack;

  // ----------------------------------------------------------------
  // Outputs to pin and core
  // ----------------------------------------------------------------
  always_comb begin
    // The core is held in every state but run; data memory has no
    // clear path and no stack pointer default is driven.
    next_core_hold = (next_state != ST_RUN);
    next_pin_oe = (next_state == ST_POR_HOLD) || (next_state == ST_POR_DELAY) ||
                  (next_state == ST_SUPPLY_HOLD);
    next_exit_pulse = leaving;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_hold <= 1'b1;
      reset_pin_oe <= 1'b1;
      core_exit_pulse <= 1'b0;
    end else begin
      core_hold <= next_core_hold;
      reset_pin_oe <= next_pin_oe;
      core_exit_pulse <= next_exit_pulse;
    end
  end

  // Fixed defaults, held in flops so the outputs are clean.
  always_ff @(posedge ref_clk) begin
    reset_pin_out <= 1'b0;
    port_latch_init <= PORT_LATCH_RESET;
    port_open_drain <= 1'b1;
    weak_pullup_en <= 1'b1;
    start_address <= START_ADDR;
    sysclk_internal_sel <= 1'b1;
    watchdog_run <= 1'b1;
    watchdog_prescale <= WDT_PRESCALE;
  end

endmodule // rsc_reset_source_controller

// *** verification/rsc_line_model.sv ***
// Behavioural model of the supply monitor and the external reset circuitry.
`timescale 1ns/10ps
module rsc_line_model (
  // Commands from the bench.
  input wire logic supply_good,
  input wire logic press,
  // Open-drain drive from the block.
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  // Lines seen by the block.
  output logic supply_above_threshold,
  output logic reset_pin_in
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  // The monitor reports the supply level as commanded.
  assign supply_above_threshold = supply_good;
  // The pin has an external pull-up, so a released pin reads high.
  assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || press);
endmodule // rsc_line_model

// *** verification/rsc_reset_source_controller_sva.sv ***
// Concurrent checks on the ports of the reset source controller.
`timescale 1ns/10ps
module rsc_reset_source_controller_sva
  import rsc_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = POR_DELAY_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus.
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // Monitor and pin.
  input wire logic supply_above_threshold,
  input wire logic supply_monitor_on,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  // Core side.
  input wire logic flash_write_attempt,
  input wire logic core_hold,
  input wire logic core_exit_pulse,
  input wire logic [7:0] port_latch_init,
  input wire logic port_open_drain,
  input wire logic weak_pullup_en,
  input wire logic [15:0] start_address,
  input wire logic sysclk_internal_sel,
  input wire logic watchdog_run,
  input wire logic [3:0] watchdog_prescale
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Monitor-select shadow
  // ----------------------------------------
  logic sel; // Monitor chosen as reset source.
  logic next_sel; // Next value of the shadow.
  // A taken write to the cause register updates the selection.
  always_comb begin
    next_sel = sel;
    if (write && !waitrequest && address == CAUSE_ADDR && byteenable[0]) begin
      next_sel = writedata[POR_FLAG_BIT];
    end
  end
  // Power-on reset selects the monitor.
  always_ff @(posedge ref_clk) begin
    sel <= reset ? 1'b1 : next_sel;
  end
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_ctrl_write;
    write && !waitrequest && address == MON_CTRL_ADDR && byteenable[0];
  endsequence
  sequence s_supply_low;
    (!supply_above_threshold && supply_monitor_on && sel && !core_hold) [*3];
  endsequence
  AST_BUS_WAIT: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus wait not one cycle");
  AST_DEFAULTS: assert property (core_hold |-> port_latch_init == PORT_LATCH_RESET && port_open_drain && weak_pullup_en)
    else $error("port defaults wrong in reset");
  AST_EXIT_DEFAULTS: assert property (core_exit_pulse |-> start_address == START_ADDR && sysclk_internal_sel)
    else $error("exit defaults wrong");
  AST_WATCHDOG: assert property (core_exit_pulse |-> watchdog_run && watchdog_prescale == WDT_PRESCALE)
    else $error("watchdog not running at exit");
  AST_EXIT_PULSE: assert property (core_exit_pulse |-> !core_hold && $past(core_hold) ##1 !core_exit_pulse)
    else $error("exit pulse misplaced");
  AST_PIN_DRIVE: assert property (reset_pin_oe |-> core_hold && !reset_pin_out)
    else $error("pin driven outside reset");
  AST_PIN_RESET: assert property ((!reset_pin_in && !reset_pin_oe) [*8] |-> ##[0:2] core_hold)
    else $error("pin low did not reset");
  AST_FLASH: assert property (flash_write_attempt && !supply_monitor_on && !core_hold |-> ##[1:4] core_hold)
    else $error("flash write with monitor off did not reset");
  AST_SUPPLY: assert property (s_supply_low |-> ##[0:4] (core_hold && reset_pin_oe))
    else $error("supply low did not reset");
  AST_MON_WRITE: assert property (s_ctrl_write |-> ##2 supply_monitor_on == $past(writedata[MON_EN_BIT], 2))
    else $error("monitor enable not followed");
endmodule // rsc_reset_source_controller_sva

bind rsc_reset_source_controller rsc_reset_source_controller_sva #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) u_sva (
  .ref_clk, .reset, .address, .read, .write, .writedata, .byteenable, .waitrequest,
  .supply_above_threshold, .supply_monitor_on, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
  .flash_write_attempt, .core_hold, .core_exit_pulse, .port_latch_init, .port_open_drain,
  .weak_pullup_en, .start_address, .sysclk_internal_sel, .watchdog_run, .watchdog_prescale
);

// *** verification/rsc_reset_source_controller_bench.sv ***
// Self-checking bench for the reset source controller.
`timescale 1ns/10ps
module rsc_reset_source_controller_bench;
  import rsc_pkg::*;
  // Short power-on delay for simulation. It must outlast the monitor settling count (SETTLE_CYC),
  // or the first exit from power-up falls straight into a supply reset.
  localparam int POR_SIM = 150;
  logic ref_clk, reset, read, write, waitrequest, supply_good, press, flash_write_attempt;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, watchdog_prescale;
  logic supply_above_threshold, supply_monitor_on, reset_pin_in, reset_pin_out, reset_pin_oe;
  logic core_hold, core_exit_pulse, port_open_drain, weak_pullup_en, sysclk_internal_sel, watchdog_run;
  logic [7:0] port_latch_init, q;
  logic [15:0] start_address;
  int errors, n_checks, n;
  rsc_reset_source_controller #(.POR_DELAY_CYCLES(POR_SIM)) rsc_reset_source_controller_i (
    .ref_clk, .reset, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .supply_above_threshold, .supply_monitor_on, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .flash_write_attempt, .core_hold, .core_exit_pulse, .port_latch_init, .port_open_drain,
    .weak_pullup_en, .start_address, .sysclk_internal_sel, .watchdog_run, .watchdog_prescale);
  rsc_line_model rsc_line_model_i (.supply_good, .press, .reset_pin_out, .reset_pin_oe,
    .supply_above_threshold, .reset_pin_in);
  // 25 MHz clock.
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Verdict and end of run, reached from the main flow and from timeouts.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compare one value against its expectation.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  // One bus access; the request is held until waitrequest is sampled low.
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      errors++;
      report_and_stop();
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Read a register and compare the masked low byte.
  task automatic rdc(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    acc(1'b0, a, 8'h00, 4'hf);
    chk({24'h0, q & mask}, {24'h0, exp}, "register read");
  endtask
  // Wait, bounded, for the core hold (mode 1) or the exit pulse (mode 0).
  task automatic wait_on(input logic mode);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((mode ? core_hold : core_exit_pulse) !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 0; reset = 1; read = 0; write = 0; address = '0; writedata = '0; byteenable = 4'hf;
    supply_good = 0; press = 0; flash_write_attempt = 0; errors = 0; n_checks = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    // Power-up with the supply still low.
    repeat (10) @(posedge ref_clk);
    chk(core_hold, 1'b1, "held during power-up");
    chk(reset_pin_oe, 1'b1, "pin driven in power-up");
    supply_good <= 1'b1;
    wait_on(1'b0);
    chk(n >= POR_SIM, 1'b1, "power-on delay");
    chk(start_address, START_ADDR, "start address");
    chk({sysclk_internal_sel, watchdog_run, watchdog_prescale}, 6'h3c, "clock and watchdog");
    chk(port_latch_init, 8'hff, "port latch");
    rdc(CAUSE_ADDR, 8'h43, 8'h02);
    rdc(MON_CTRL_ADDR, 8'hc0, 8'hc0);
    rdc(4'h8, 8'hff, 8'h00);
    $display("test power_on done");
    // Pin reset.
    press <= 1'b1;
    wait_on(1'b1);
    repeat (5) @(posedge ref_clk);
    press <= 1'b0;
    wait_on(1'b0);
    rdc(CAUSE_ADDR, 8'h43, 8'h01);
    rdc(MON_CTRL_ADDR, 8'h80, 8'h80);
    $display("test pin_reset done");
    // Supply drop; status read while held.
    supply_good <= 1'b0;
    wait_on(1'b1);
    repeat (2) @(posedge ref_clk);
    chk(reset_pin_oe, 1'b1, "pin driven in supply reset");
    rdc(MON_CTRL_ADDR, 8'hc0, 8'h80);
    supply_good <= 1'b1;
    wait_on(1'b0);
    rdc(CAUSE_ADDR, 8'h43, 8'h02);
    rdc(MON_CTRL_ADDR, 8'hc0, 8'hc0);
    $display("test supply_reset done");
    // Monitor off, masked write refused, pin reset keeps it off.
    acc(1'b1, MON_CTRL_ADDR, 8'h00, 4'hf);
    repeat (3) @(posedge ref_clk);
    chk(supply_monitor_on, 1'b0, "monitor off");
    acc(1'b1, MON_CTRL_ADDR, 8'h80, 4'he);
    rdc(MON_CTRL_ADDR, 8'h80, 8'h00);
    press <= 1'b1;
    wait_on(1'b1);
    press <= 1'b0;
    wait_on(1'b0);
    rdc(MON_CTRL_ADDR, 8'h80, 8'h00);
    // Flash write while the monitor is off.
    flash_write_attempt <= 1'b1;
    @(posedge ref_clk);
    flash_write_attempt <= 1'b0;
    wait_on(1'b1);
    wait_on(1'b0);
    rdc(CAUSE_ADDR, 8'h43, 8'h40);
    $display("test monitor_off done");
    // Enabling while still selected resets at once; then rewrite the cause.
    acc(1'b1, MON_CTRL_ADDR, 8'h80, 4'hf);
    wait_on(1'b1);
    wait_on(1'b0);
    chk(supply_monitor_on, 1'b1, "monitor kept on");
    acc(1'b1, CAUSE_ADDR, 8'h02, 4'hf);
    repeat (20) @(posedge ref_clk);
    chk(core_hold, 1'b0, "settled monitor runs");
    $display("test monitor_select done");
    report_and_stop();
  end
endmodule // rsc_reset_source_controller_bench
